// [shared/rpec_defines.svh]
// Offsets, field positions, reset values and counts for the root port enable/connect block.
`ifndef RPEC_DEFINES_SVH
`define RPEC_DEFINES_SVH

`define RPEC_ADDR_W        4
`define RPEC_OFS_PORTSTAT  4'h0
`define RPEC_OFS_IRQSTAT   4'h4
`define RPEC_OFS_IRQMASK   4'h8
`define RPEC_OFS_CTRL      4'hC

`define RPEC_BIT_ATTACH    0
`define RPEC_BIT_ENABLE    1
`define RPEC_BIT_SUSPEND   2
`define RPEC_BIT_RESUME    3
`define RPEC_BIT_RESET     4
`define RPEC_BIT_ATT_CHG   16
`define RPEC_BIT_ENA_CHG   17
`define RPEC_BIT_SUS_CHG   18
`define RPEC_BIT_RST_CHG   20

`define RPEC_IRQ_W         4
`define RPEC_IRQ_ATT       0
`define RPEC_IRQ_ENA       1
`define RPEC_IRQ_SUS       2
`define RPEC_IRQ_RST       3
`define RPEC_IRQ_RST_VAL   4'h0

`define RPEC_CTRL_FIXED    0

`define RPEC_RST_TIME_NS   10000
`define RPEC_CLK_NS        25
`define RPEC_RST_CYC       ((`RPEC_RST_TIME_NS + `RPEC_CLK_NS - 1) / `RPEC_CLK_NS)
`define RPEC_SUS_TIME_NS   20000
`define RPEC_SUS_CYC       ((`RPEC_SUS_TIME_NS + `RPEC_CLK_NS - 1) / `RPEC_CLK_NS)
`define RPEC_CNT_W         10

`endif

// [shared/rpec_pkg.sv]
// Types for the root port enable/connect block.
`default_nettype none
package rpec_pkg;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rpec_req_t;

  typedef enum logic [2:0] {
    RPEC_IDLE = 3'b001,
    RPEC_RST  = 3'b010,
    RPEC_RES  = 3'b100
  } rpec_seq_t;

endpackage

`default_nettype wire

// [design/rpec_port.sv]
// Root port enable and connect status logic with register port and interrupt.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rpec_defines.svh"

module rpec_port
  import rpec_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Register port.
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Port pins and fault inputs.
  input  wire logic        attach_pin_i,
  input  wire logic        overcurrent_i,
  input  wire logic        power_off_i,
  input  wire logic        bus_error_i,
  // Interrupt.
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] att_sync_ff;
  logic [2:0] oc_sync_ff;
  logic [2:0] pwr_sync_ff;
  logic [2:0] err_sync_ff;
  logic       att_ff;
  logic       oc_ff;
  logic       pwr_ff;
  logic       err_ff;
  logic [2:0] nxt_att_sync;
  logic [2:0] nxt_oc_sync;
  logic [2:0] nxt_pwr_sync;
  logic [2:0] nxt_err_sync;
  logic       nxt_att;
  logic       nxt_oc;
  logic       nxt_pwr;
  logic       nxt_err;

  // Filtered level follows once the second and third stages agree.
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  always_comb begin
    nxt_att_sync = {att_sync_ff[1:0], attach_pin_i};
    nxt_oc_sync  = {oc_sync_ff[1:0], overcurrent_i};
    nxt_pwr_sync = {pwr_sync_ff[1:0], power_off_i};
    nxt_err_sync = {err_sync_ff[1:0], bus_error_i};
    nxt_att      = filt(att_sync_ff, att_ff);
    nxt_oc       = filt(oc_sync_ff, oc_ff);
    nxt_pwr      = filt(pwr_sync_ff, pwr_ff);
    nxt_err      = filt(err_sync_ff, err_ff);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      att_sync_ff <= 3'h0;
      oc_sync_ff  <= 3'h0;
      pwr_sync_ff <= 3'h0;
      err_sync_ff <= 3'h0;
      att_ff      <= 1'b0;
      oc_ff       <= 1'b0;
      pwr_ff      <= 1'b0;
      err_ff      <= 1'b0;
    end else begin
      att_sync_ff <= nxt_att_sync;
      oc_sync_ff  <= nxt_oc_sync;
      pwr_sync_ff <= nxt_pwr_sync;
      err_sync_ff <= nxt_err_sync;
      att_ff      <= nxt_att;
      oc_ff       <= nxt_oc;
      pwr_ff      <= nxt_pwr;
      err_ff      <= nxt_err;
    end
  end

  // ---------------------------------------------------------------
  // Port state
  // ---------------------------------------------------------------
  logic                   enable_ff;
  logic                   suspend_ff;
  logic                   fixed_ff;
  logic                   att_chg_ff;
  logic                   ena_chg_ff;
  logic                   sus_chg_ff;
  logic                   rst_chg_ff;
  logic [`RPEC_IRQ_W-1:0] irq_mask_ff;
  logic [`RPEC_CNT_W-1:0] cnt_ff;
  rpec_seq_t              seq_ff;
  logic                   att_prev_ff;
  logic                   nxt_enable;
  logic                   nxt_suspend;
  logic                   nxt_fixed;
  logic                   nxt_att_chg;
  logic                   nxt_ena_chg;
  logic                   nxt_sus_chg;
  logic                   nxt_rst_chg;
  logic [`RPEC_IRQ_W-1:0] nxt_irq_mask;
  logic [`RPEC_CNT_W-1:0] nxt_cnt;
  rpec_seq_t              nxt_seq;
  logic                   attached;
  logic                   fault;
  logic                   rst_done;
  logic                   res_done;
  logic                   wr_stat;
  logic                   wr_irq;

  // Attached view includes the fixed device mask.
  // fixed reads attached
  assign attached = att_ff | fixed_ff;
  assign wr_stat  = wr_i && (addr_i == `RPEC_OFS_PORTSTAT);
  assign wr_irq   = wr_i && (addr_i == `RPEC_OFS_IRQSTAT);
  assign rst_done = (seq_ff == RPEC_RST) && (cnt_ff == `RPEC_CNT_W'(`RPEC_RST_CYC - 1));
  assign res_done = (seq_ff == RPEC_RES) && (cnt_ff == `RPEC_CNT_W'(`RPEC_SUS_CYC - 1));
  assign fault    = oc_ff | pwr_ff | err_ff | (att_prev_ff & ~attached);

  always_comb begin
    nxt_enable   = enable_ff;
    nxt_suspend  = suspend_ff;
    nxt_fixed    = fixed_ff;
    nxt_att_chg  = att_chg_ff;
    nxt_ena_chg  = ena_chg_ff;
    nxt_sus_chg  = sus_chg_ff;
    nxt_rst_chg  = rst_chg_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_cnt      = cnt_ff + `RPEC_CNT_W'(1);
    nxt_seq      = seq_ff;
    // Clears by software first; hardware sets below win.
    // write one clears
    if (wr_irq) begin
      if (wdata_i[`RPEC_IRQ_ATT]) nxt_att_chg = 1'b0;
      if (wdata_i[`RPEC_IRQ_ENA]) nxt_ena_chg = 1'b0;
      if (wdata_i[`RPEC_IRQ_SUS]) nxt_sus_chg = 1'b0;
      if (wdata_i[`RPEC_IRQ_RST]) nxt_rst_chg = 1'b0;
    end
    if (wr_i && (addr_i == `RPEC_OFS_IRQMASK)) nxt_irq_mask = wdata_i[`RPEC_IRQ_W-1:0];
    if (wr_i && (addr_i == `RPEC_OFS_CTRL)) nxt_fixed = wdata_i[`RPEC_CTRL_FIXED];
    if (wr_stat) begin
      if (wdata_i[`RPEC_BIT_ATTACH]) nxt_enable = 1'b0;
      if (wdata_i[`RPEC_BIT_ENABLE]) begin
        if (attached) begin
          nxt_enable = 1'b1;
        end else begin
          nxt_att_chg = 1'b1;
        end
      end
      if (wdata_i[`RPEC_BIT_RESET] && seq_ff == RPEC_IDLE) begin
        if (attached) begin
          nxt_seq = RPEC_RST;
          nxt_cnt = '0;
        end else begin
          nxt_att_chg = 1'b1;
        end
      end
      if (wdata_i[`RPEC_BIT_SUSPEND]) begin
        if (attached) begin
          nxt_suspend = 1'b1;
        end else begin
          nxt_att_chg = 1'b1;
        end
      end
      if (wdata_i[`RPEC_BIT_RESUME] && seq_ff == RPEC_IDLE && suspend_ff) begin
        nxt_seq = RPEC_RES;
        nxt_cnt = '0;
      end
    end
    case (seq_ff)
      RPEC_RST: begin
        if (rst_done) begin
          nxt_seq     = RPEC_IDLE;
          nxt_rst_chg = 1'b1;
          nxt_suspend = 1'b0;
          nxt_enable  = 1'b1;
        end
      end
      RPEC_RES: begin
        if (res_done) begin
          nxt_seq     = RPEC_IDLE;
          nxt_sus_chg = 1'b1;
          nxt_suspend = 1'b0;
          nxt_enable  = 1'b1;
        end
      end
      RPEC_IDLE: nxt_cnt = '0;
      default:   nxt_seq = RPEC_IDLE;
    endcase
    if (att_prev_ff != attached) nxt_att_chg = 1'b1;
    if (fault && (enable_ff || nxt_enable)) begin
      nxt_enable  = 1'b0;
      nxt_ena_chg = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      enable_ff   <= 1'b0;
      suspend_ff  <= 1'b0;
      fixed_ff    <= 1'b0;
      att_chg_ff  <= 1'b0;
      ena_chg_ff  <= 1'b0;
      sus_chg_ff  <= 1'b0;
      rst_chg_ff  <= 1'b0;
      irq_mask_ff <= `RPEC_IRQ_RST_VAL;
      cnt_ff      <= '0;
      seq_ff      <= RPEC_IDLE;
      att_prev_ff <= 1'b0;
    end else begin
      enable_ff   <= nxt_enable;
      suspend_ff  <= nxt_suspend;
      fixed_ff    <= nxt_fixed;
      att_chg_ff  <= nxt_att_chg;
      ena_chg_ff  <= nxt_ena_chg;
      sus_chg_ff  <= nxt_sus_chg;
      rst_chg_ff  <= nxt_rst_chg;
      irq_mask_ff <= nxt_irq_mask;
      cnt_ff      <= nxt_cnt;
      seq_ff      <= nxt_seq;
      att_prev_ff <= attached;
    end
  end

  // ---------------------------------------------------------------
  // Read data and interrupt
  // ---------------------------------------------------------------
  logic [31:0]            nxt_rdata;
  logic [`RPEC_IRQ_W-1:0] irq_stat;
  logic                   nxt_irq;

  assign irq_stat = {rst_chg_ff, sus_chg_ff, ena_chg_ff, att_chg_ff};

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_irq   = |(nxt_irq_mask & {nxt_rst_chg, nxt_sus_chg, nxt_ena_chg, nxt_att_chg});
    if (rd_i) begin
      case (addr_i)
        `RPEC_OFS_PORTSTAT: begin
          nxt_rdata[`RPEC_BIT_ENABLE]  = enable_ff;
          nxt_rdata[`RPEC_BIT_ATTACH]  = attached;
          nxt_rdata[`RPEC_BIT_SUSPEND] = suspend_ff;
          nxt_rdata[`RPEC_BIT_RESET]   = (seq_ff == RPEC_RST);
          nxt_rdata[`RPEC_BIT_ATT_CHG] = att_chg_ff;
          nxt_rdata[`RPEC_BIT_ENA_CHG] = ena_chg_ff;
          nxt_rdata[`RPEC_BIT_SUS_CHG] = sus_chg_ff;
          nxt_rdata[`RPEC_BIT_RST_CHG] = rst_chg_ff;
        end
        `RPEC_OFS_IRQSTAT: nxt_rdata[`RPEC_IRQ_W-1:0] = irq_stat;
        `RPEC_OFS_IRQMASK: nxt_rdata[`RPEC_IRQ_W-1:0] = irq_mask_ff;
        `RPEC_OFS_CTRL:    nxt_rdata[`RPEC_CTRL_FIXED] = fixed_ff;
        default:           nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
      irq_o   <= 1'b0;
    end else begin
      rdata_o <= nxt_rdata;
      irq_o   <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_enable_read_bit: assert property (rd_i && addr_i == `RPEC_OFS_PORTSTAT |=> rdata_o[1] == $past(enable_ff))
    else $error("enable bit read mismatch");
  a_fault_drops_en: assert property (fault |=> !enable_ff)
    else $error("enable kept through fault");
  a_drop_sets_chg: assert property ($fell(enable_ff) && !$past(wr_stat) |-> ena_chg_ff)
    else $error("hardware drop without change flag");
  a_reset_done_en: assert property (rst_done && !fault |=> enable_ff && rst_chg_ff)
    else $error("reset completion did not enable");
  a_resume_done_en: assert property (res_done && !fault |=> enable_ff && sus_chg_ff && !suspend_ff)
    else $error("resume completion did not enable");
  a_write_enable: assert property (wr_stat && wdata_i[1] && !wdata_i[0] && attached && !fault |=> enable_ff)
    else $error("set enable ignored");
  a_detached_enable: assert property (wr_stat && wdata_i[1] && !attached |=> att_chg_ff)
    else $error("detached enable did not flag");
  a_live_attach: assert property (rd_i && addr_i == `RPEC_OFS_PORTSTAT |=> rdata_o[0] == $past(attached))
    else $error("attach bit read mismatch");
  a_write_disable: assert property (wr_stat && wdata_i[0] && !wdata_i[1] && seq_ff == RPEC_IDLE |=> !enable_ff)
    else $error("clear enable ignored");
  a_attach_no_write: assert property (wr_stat && att_sync_ff[2] == att_ff |=> attached == $past(attached))
    else $error("attach changed by write");
  a_fixed_attach: assert property (rd_i && addr_i == `RPEC_OFS_PORTSTAT && fixed_ff |=> rdata_o[0])
    else $error("fixed device not attached");
  a_reset_ends: assert property (seq_ff == RPEC_RST |-> ##[1:401] seq_ff != RPEC_RST)
    else $error("reset sequence did not end");
  a_chg_sticky: assert property (att_chg_ff && !wr_irq |=> att_chg_ff)
    else $error("change flag lost");

  c_reset_seq: cover property (seq_ff == RPEC_RST ##[1:401] rst_chg_ff);
  c_fault_drop: cover property (enable_ff ##1 fault ##1 ena_chg_ff);
  c_detached_try: cover property (wr_stat && wdata_i[1] && !attached);
  c_irq_raise: cover property ($rose(irq_o));
  c_resume_seq: cover property (seq_ff == RPEC_RES ##1 res_done ##1 sus_chg_ff);

endmodule

`default_nettype wire

// [bench/rpec_usb_dev.sv]
// Behavioural downstream device that drives the attach pin of the root port.
`timescale 1ns/1ps
`default_nettype none

module rpec_usb_dev (
  // Clock.
  input  wire logic ref_clk_i,
  // Bench control.
  input  wire logic plug_i,
  // Port pin.
  output var logic  attach_o
);
  // The attach level follows the plug one cycle late, as a slow cable would.
  initial attach_o = 1'b0;
  always @(posedge ref_clk_i) begin
    attach_o <= plug_i;
  end
endmodule

`default_nettype wire

// [bench/rpec_port_bench.sv]
// Self-checking bench for the root port enable and connect block.
`timescale 1ns/1ps
`default_nettype none

module rpec_port_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  addr_i    = 4'h0;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rdata_o;
  logic        plug      = 1'b0;
  logic        attach;
  logic [2:0]  fault     = 3'h0;
  logic        irq_o;
  int          n_fail;
  int          samples_checked;
  logic [31:0] d;

  rpec_port i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .attach_pin_i(attach), .overcurrent_i(fault[0]),
    .power_off_i(fault[1]), .bus_error_i(fault[2]), .irq_o(irq_o));
  rpec_usb_dev i_dev (.ref_clk_i(ref_clk_i), .plug_i(plug), .attach_o(attach));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_attach;
    rd(4'h0);
    chk(d, 32'h0);
    plug <= 1'b1;
    cyc(8);
    rd(4'h0);
    chk(d, 32'h0001_0001);
    wr(4'h0, 32'hFFFF_FFE9);
    rd(4'h0);
    chk(d, 32'h0001_0001);
    $display("attach test done");
  endtask

  task automatic t_enable;
    wr(4'h0, 32'h0);
    rd(4'h0);
    chk(d, 32'h0001_0001);
    wr(4'h0, 32'h2);
    rd(4'h0);
    chk(d, 32'h0001_0003);
    wr(4'h0, 32'h0);
    rd(4'h0);
    chk(d, 32'h0001_0003);
    wr(4'h0, 32'h1);
    rd(4'h0);
    chk(d, 32'h0001_0001);
    wr(4'h4, 32'hF);
    rd(4'h0);
    chk(d, 32'h0000_0001);
    $display("enable test done");
  endtask

  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 32'h2);
      fault <= 3'(1 << i);
      cyc(8);
      fault <= 3'h0;
      cyc(8);
      rd(4'h0);
      chk(d, 32'h0002_0001);
      rd(4'h4);
      chk(d, 32'h2);
      wr(4'h4, 32'h2);
    end
    $display("fault test done");
  endtask

  task automatic t_irq;
    wr(4'h8, 32'h2);
    wr(4'h0, 32'h2);
    fault[0] <= 1'b1;
    cyc(8);
    fault[0] <= 1'b0;
    cyc(3);
    chk({31'h0, irq_o}, 32'h1);
    wr(4'h8, 32'h0);
    cyc(3);
    chk({31'h0, irq_o}, 32'h0);
    wr(4'h8, 32'h2);
    cyc(3);
    chk({31'h0, irq_o}, 32'h1);
    wr(4'h4, 32'h2);
    cyc(3);
    chk({31'h0, irq_o}, 32'h0);
    $display("interrupt test done");
  endtask

  task automatic t_detach;
    wr(4'h0, 32'h2);
    plug <= 1'b0;
    cyc(8);
    rd(4'h0);
    chk(d, 32'h0003_0000);
    wr(4'h4, 32'hF);
    wr(4'h0, 32'h2);
    rd(4'h0);
    chk(d, 32'h0001_0000);
    wr(4'h4, 32'hF);
    $display("detach test done");
  endtask

  task automatic t_port_reset;
    plug <= 1'b1;
    cyc(8);
    wr(4'h4, 32'hF);
    wr(4'h0, 32'h10);
    rd(4'h0);
    chk(d, 32'h0000_0011);
    cyc(380);
    rd(4'h0);
    chk(d, 32'h0000_0011);
    cyc(30);
    rd(4'h0);
    chk(d, 32'h0010_0003);
    $display("port reset test done");
  endtask

  task automatic t_resume;
    wr(4'h4, 32'hF);
    wr(4'h0, 32'h1);
    wr(4'h0, 32'h4);
    rd(4'h0);
    chk(d, 32'h0000_0005);
    wr(4'h0, 32'h8);
    cyc(790);
    rd(4'h0);
    chk(d, 32'h0000_0005);
    cyc(20);
    rd(4'h0);
    chk(d, 32'h0004_0003);
    $display("resume test done");
  endtask

  task automatic t_fixed;
    wr(4'hC, 32'h1);
    plug <= 1'b0;
    cyc(8);
    rd(4'h0);
    chk({31'h0, d[0]}, 32'h1);
    rd(4'hC);
    chk(d, 32'h1);
    rd(4'h2);
    chk(d, 32'h0);
    $display("fixed device test done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    samples_checked = 0;
    cyc(3);
    rst_i <= 1'b0;
    t_attach();
    t_enable();
    t_fault();
    t_irq();
    t_detach();
    t_port_reset();
    t_resume();
    t_fixed();
    end_sim();
  end

  initial begin
    cyc(5000);
    n_fail++;
    end_sim();
  end
endmodule

`default_nettype wire
